// [pkg/efp_pkg.sv]
// Constants and types for the event flag and packet option register bank.
// Assumes one clock domain and a byte-wide register command port.
// Behaviour
// - Three byte flag registers, one bit per event
// - Event line: flag and mask, legacy mask zero
// - Flag reads leave every bit unchanged
// - Flag write stores current AND written value
// - Writes never set; some flags clear internally
// - Transmit done after send with no ack request, or after acknowledgement
// - Receive waiting follows undelivered buffered bytes
// - Plaintext flag on accepted unencrypted packet
// - Sequence decrease flag on lower sequence
// - Sequence gap flag when jump exceeds one
// - Join started flag when join begins
// - Low byte holds eight error events
// - Reserved flag bits never set
// - Packet options at two addresses, bits 7:4 zero
// - Implicit mode: four triggers launch packet
// - Explicit mode: only command or line low
// - Packet length snapshot at trigger instant
// - Explicit mode bit change flushes buffer
// - Line fall acts as send command
// - Explicit receive waits for fetch command
// - Implicit receive streams paced by hold setting
// - Status option selects clear-to-send use
// - Mask registers at 0xD0 to 0xD2
// - Plaintext packet dropped when not accepted
package efp_pkg;
    // ========================================================
    // Register map
    localparam logic [7:0] ADDR_FLAG_HIGH  = 8'hCD;
    localparam logic [7:0] ADDR_FLAG_MID   = 8'hCE;
    localparam logic [7:0] ADDR_FLAG_LOW   = 8'hCF;
    localparam logic [7:0] ADDR_MASK_HIGH  = 8'hD0;
    localparam logic [7:0] ADDR_MASK_MID   = 8'hD1;
    localparam logic [7:0] ADDR_MASK_LOW   = 8'hD2;
    localparam logic [7:0] ADDR_OPT_VOL    = 8'hD3;
    localparam logic [7:0] ADDR_OPT_NV     = 8'h83;
    // ========================================================
    // Field layout and reset values
    localparam logic [7:0] FLAG_MID_USED   = 8'h3F;
    localparam logic [7:0] OPT_USED        = 8'h0F;
    localparam logic [7:0] FLAG_RESET      = 8'h00;
    localparam logic [7:0] MASK_RESET      = 8'h00;
    localparam logic [7:0] OPT_RESET       = 8'h00;
    localparam logic [7:0] READ_UNMAPPED   = 8'h00;
    localparam int         MID_TXDONE      = 0;
    localparam int         MID_RXWAIT      = 1;
    localparam int         MID_PLAIN       = 2;
    localparam int         MID_SEQDEC      = 3;
    localparam int         MID_SEQGAP      = 4;
    localparam int         MID_JOIN        = 5;
    localparam int         OPT_TX_EXPL     = 0;
    localparam int         OPT_TX_LOW      = 1;
    localparam int         OPT_RX_EXPL     = 2;
    localparam int         OPT_CTS_STAT    = 3;
    localparam int         SEQ_W           = 16;
    localparam int         LEN_W           = 8;
    localparam logic [SEQ_W-1:0] SEQ_ONE   = 16'h0001;
    // ========================================================
    // Low byte error events, bit 7 first
    typedef struct packed {
        logic unsupported_frame_flag;
        logic ack_sequence_mismatch_flag;
        logic header_checksum_error_flag;
        logic payload_checksum_error_flag;
        logic missing_acknowledge_flag;
        logic register_write_failure_flag;
        logic radio_buffer_overflow_flag;
        logic serial_buffer_overflow_flag;
    } efp_err_evt_t;
    // Transmit and join events, one-cycle pulses
    typedef struct packed {
        logic packet_sent;
        logic ack_requested;
        logic ack_received;
        logic join_begin;
    } efp_tx_evt_t;
    // Received packet report, valid for one cycle
    typedef struct packed {
        logic             valid;
        logic             encrypted;
        logic [SEQ_W-1:0] seq;
    } efp_rx_pkt_t;
    // Transmit trigger sources from the data path
    typedef struct packed {
        logic count_reached;
        logic idle_expired;
        logic slot_exceeded;
        logic send_cmd;
    } efp_tx_trig_t;
    // Fetch commands for explicit receive mode
    typedef enum logic [1:0] {
        EFP_FETCH_NONE,
        EFP_FETCH_HEADER,
        EFP_FETCH_PAYLOAD,
        EFP_FETCH_BOTH
    } efp_fetch_t;
endpackage : efp_pkg

// [core/efp_regbank.sv]
// Event flag, event mask and packet option registers with their effects.
// Assumes a frame parser outside that issues single-cycle byte accesses.
`timescale 1ns/1ps
module efp_regbank
    import efp_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output logic      [7:0]         reg_rdata,
    output logic                    reg_rvalid,
    input  wire logic [7:0]         legacy_event_mask,
    input  wire logic               accept_plaintext_option,
    input  wire efp_err_evt_t       err_evt,
    input  wire efp_tx_evt_t        tx_evt,
    input  wire efp_rx_pkt_t        rx_pkt,
    input  wire logic               rx_bytes_pending,
    input  wire efp_tx_trig_t       tx_trig,
    input  wire logic               cmd_line_n,
    input  wire logic [LEN_W-1:0]   tx_buffered_len,
    input  wire efp_fetch_t         rx_fetch,
    output logic                    event_line,
    output logic                    tx_launch,
    output logic      [LEN_W-1:0]   tx_packet_len,
    output logic                    tx_flush,
    output logic                    rx_drop,
    output logic                    rx_hold_packets,
    output logic                    rx_stream_paced,
    output efp_fetch_t              rx_deliver,
    output logic                    cts_carries_status,
    output logic                    command_response_line_carries_status
);
    // ========================================================
    // State
    logic [7:0]         flag_mid_ff;
    logic [7:0]         flag_low_ff;
    logic [7:0]         mask_high_ff;
    logic [7:0]         mask_mid_ff;
    logic [7:0]         mask_low_ff;
    logic [7:0]         opt_vol_ff;
    logic [7:0]         opt_nv_ff;
    logic [7:0]         rdata_ff;
    logic               rvalid_ff;
    logic [SEQ_W-1:0]   prev_seq_ff;
    logic               have_prev_ff;
    logic               cmd_prev_n_ff;
    logic               tx_mode_prev_ff;
    logic               launch_ff;
    logic [LEN_W-1:0]   len_ff;
    logic               flush_ff;
    logic               drop_ff;
    efp_fetch_t         deliver_ff;
    logic [7:0]         nxt_flag_mid;
    logic [7:0]         nxt_flag_low;
    logic [7:0]         set_mid;
    logic [7:0]         set_low;
    logic               wr_mid;
    logic               wr_low;
    logic               plain_pkt;
    logic               enc_pkt;
    logic               seq_lower;
    logic               seq_gap;
    logic               line_fall;
    logic               tx_expl;
    logic               trig;

    assign tx_expl   = opt_vol_ff[OPT_TX_EXPL];
    assign wr_mid    = reg_wr && (reg_addr == ADDR_FLAG_MID);
    assign wr_low    = reg_wr && (reg_addr == ADDR_FLAG_LOW);
    assign plain_pkt = rx_pkt.valid && !rx_pkt.encrypted;
    assign enc_pkt   = rx_pkt.valid && rx_pkt.encrypted;
    assign seq_lower = enc_pkt && have_prev_ff
                       && (rx_pkt.seq < prev_seq_ff);
    assign seq_gap   = enc_pkt && have_prev_ff
                       && (rx_pkt.seq > prev_seq_ff + SEQ_ONE)
                       && (prev_seq_ff != {SEQ_W{1'b1}});

    // ========================================================
    // Flag set terms
    always_comb begin
        set_low = err_evt;
        set_mid = 8'h00;
        set_mid[MID_TXDONE] = (tx_evt.packet_sent
                               && !tx_evt.ack_requested)
                              || tx_evt.ack_received;
        set_mid[MID_PLAIN]  = plain_pkt
                              && accept_plaintext_option;
        set_mid[MID_SEQDEC] = seq_lower;
        set_mid[MID_SEQGAP] = seq_gap;
        set_mid[MID_JOIN]   = tx_evt.join_begin;
    end

    // Write ANDs, set ORs afterwards so a same-cycle event survives
    always_comb begin
        nxt_flag_low = (wr_low ? (flag_low_ff & reg_wdata)
                               : flag_low_ff) | set_low;
        nxt_flag_mid = ((wr_mid ? (flag_mid_ff & reg_wdata)
                                : flag_mid_ff) | set_mid)
                       & FLAG_MID_USED;
        nxt_flag_mid[MID_RXWAIT] = rx_bytes_pending;
    end

    // ========================================================
    // Flag registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_mid_ff <= FLAG_RESET;
            flag_low_ff <= FLAG_RESET;
        end else begin
            flag_mid_ff <= nxt_flag_mid;
            flag_low_ff <= nxt_flag_low;
        end
    end

    // ========================================================
    // Mask and option registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_high_ff <= MASK_RESET;
            mask_mid_ff  <= MASK_RESET;
            mask_low_ff  <= MASK_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_MASK_HIGH) begin
                mask_high_ff <= reg_wdata;
            end
            if (reg_addr == ADDR_MASK_MID) begin
                mask_mid_ff <= reg_wdata;
            end
            if (reg_addr == ADDR_MASK_LOW) begin
                mask_low_ff <= reg_wdata;
            end
        end
    end

    // Non-volatile copy is only held here; storage lives elsewhere
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opt_vol_ff <= OPT_RESET;
            opt_nv_ff  <= OPT_RESET;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_OPT_VOL) begin
                opt_vol_ff <= reg_wdata & OPT_USED;
            end
            if (reg_addr == ADDR_OPT_NV) begin
                opt_nv_ff <= reg_wdata & OPT_USED;
            end
        end
    end

    // ========================================================
    // Read port, answer one cycle after the request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_ff  <= READ_UNMAPPED;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd;
            if (reg_rd) begin
                unique case (reg_addr)
                    ADDR_FLAG_HIGH: rdata_ff <= FLAG_RESET;
                    ADDR_FLAG_MID:  rdata_ff <= flag_mid_ff;
                    ADDR_FLAG_LOW:  rdata_ff <= flag_low_ff;
                    ADDR_MASK_HIGH: rdata_ff <= mask_high_ff;
                    ADDR_MASK_MID:  rdata_ff <= mask_mid_ff;
                    ADDR_MASK_LOW:  rdata_ff <= mask_low_ff;
                    ADDR_OPT_VOL:   rdata_ff <= opt_vol_ff;
                    ADDR_OPT_NV:    rdata_ff <= opt_nv_ff;
                    default:        rdata_ff <= READ_UNMAPPED;
                endcase
            end
        end
    end

    assign reg_rdata  = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // High flag byte is always zero, so its mask has no effect
    assign event_line = (legacy_event_mask == 8'h00)
                        && (|((flag_mid_ff & mask_mid_ff)
                              | (flag_low_ff & mask_low_ff)));

    // ========================================================
    // Sequence tracking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_seq_ff  <= {SEQ_W{1'b0}};
            have_prev_ff <= 1'b0;
        end else if (enc_pkt) begin
            prev_seq_ff  <= rx_pkt.seq;
            have_prev_ff <= 1'b1;
        end
    end

    // ========================================================
    // Transmit triggering
    assign line_fall = cmd_prev_n_ff && !cmd_line_n
                       && opt_vol_ff[OPT_TX_LOW];
    assign trig = tx_trig.send_cmd || line_fall
                  || (!tx_expl && (tx_trig.count_reached
                                   || tx_trig.idle_expired
                                   || tx_trig.slot_exceeded));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_prev_n_ff <= 1'b1;
            launch_ff     <= 1'b0;
            len_ff        <= {LEN_W{1'b0}};
        end else begin
            cmd_prev_n_ff <= cmd_line_n;
            launch_ff     <= trig && !tx_flush;
            if (trig) begin
                len_ff <= tx_buffered_len;
            end
        end
    end

    // Flush also suppresses the launch for a trigger in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_mode_prev_ff <= 1'b0;
            flush_ff        <= 1'b0;
        end else begin
            tx_mode_prev_ff <= tx_expl;
            flush_ff        <= tx_expl != tx_mode_prev_ff;
        end
    end

    assign tx_launch     = launch_ff;
    assign tx_packet_len = len_ff;
    assign tx_flush      = flush_ff;

    // ========================================================
    // Receive delivery
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drop_ff    <= 1'b0;
            deliver_ff <= EFP_FETCH_NONE;
        end else begin
            drop_ff    <= plain_pkt && !accept_plaintext_option;
            deliver_ff <= opt_vol_ff[OPT_RX_EXPL] ? rx_fetch
                                                  : EFP_FETCH_NONE;
        end
    end

    assign rx_drop              = drop_ff;
    assign rx_deliver           = deliver_ff;
    assign rx_hold_packets      = opt_vol_ff[OPT_RX_EXPL];
    assign rx_stream_paced      = !opt_vol_ff[OPT_RX_EXPL];
    assign cts_carries_status   = opt_vol_ff[OPT_CTS_STAT];
    assign command_response_line_carries_status = !opt_vol_ff[OPT_CTS_STAT];

    // ========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_LOW_SET_WINS: assert property (
        wr_low && (set_low != 8'h00)
        |=> (flag_low_ff & $past(set_low)) == $past(set_low))
        else $error("Low flag lost under same-cycle clear");
    AST_WRITE_AND: assert property (
        wr_low && (err_evt == 8'h00)
        |=> flag_low_ff == ($past(flag_low_ff) & $past(reg_wdata)))
        else $error("Flag write is not an AND");
    AST_NO_WRITE_SET: assert property (
        wr_low && (set_low == 8'h00)
        |=> (flag_low_ff & ~$past(flag_low_ff)) == 8'h00)
        else $error("Host write set a low flag bit");
    AST_JOIN_NOSET: assert property (
        !flag_mid_ff[MID_JOIN] && !tx_evt.join_begin
        |=> !flag_mid_ff[MID_JOIN])
        else $error("Join flag set without event");
    AST_READ_KEEPS: assert property (
        reg_rd && !reg_wr && (set_low == 8'h00)
        |=> $stable(flag_low_ff))
        else $error("Read changed low flags");
    AST_EVENT_LINE: assert property (
        (legacy_event_mask != 8'h00) |-> !event_line)
        else $error("Event line with legacy mask set");
    AST_RESERVED: assert property (
        flag_mid_ff[7:6] == 2'b00)
        else $error("Reserved flag bit set");
    AST_RXWAIT: assert property (
        rx_bytes_pending |=> flag_mid_ff[MID_RXWAIT])
        else $error("Receive waiting flag not held");
    AST_TXDONE_ACK: assert property (
        tx_evt.packet_sent && tx_evt.ack_requested
        && !tx_evt.ack_received && !flag_mid_ff[MID_TXDONE]
        |=> !flag_mid_ff[MID_TXDONE])
        else $error("Transmit done before acknowledgement");
    AST_EXPL_IGNORE: assert property (
        tx_expl && !tx_trig.send_cmd && !line_fall |=> !tx_launch)
        else $error("Explicit mode launched on timer or count");
    AST_SNAPSHOT: assert property (
        trig ##1 1 |-> tx_packet_len == $past(tx_buffered_len))
        else $error("Packet length not taken at trigger");
    AST_FLUSH: assert property (
        $changed(tx_expl) |=> tx_flush)
        else $error("Mode change did not flush");
    AST_DROP: assert property (
        plain_pkt && !accept_plaintext_option
        |=> rx_drop)
        else $error("Plaintext packet not dropped");
    AST_OPT_RSVD: assert property (
        opt_vol_ff[7:4] == 4'h0 && opt_nv_ff[7:4] == 4'h0)
        else $error("Option reserved bits stored");

    COV_LINE_TRIG: cover property (line_fall ##1 tx_launch);
    COV_EVENT:     cover property (!event_line ##1 event_line);
    COV_SEQ_GAP:   cover property (seq_gap ##1 flag_mid_ff[MID_SEQGAP]);
    COV_FLUSH:     cover property (tx_flush);
endmodule : efp_regbank

// [verif/efp_host_model.sv]
// Host model: drives the register port, the command line and fetches.
// Assumes the bench calls one of its tasks at a time.
`timescale 1ns/1ps
module efp_host_model
    import efp_pkg::*;
(
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic            cmd_line_n,
    output efp_fetch_t      rx_fetch
);
    // ========
    // Idle levels
    initial begin
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 8'h00;
        cmd_line_n = 1'b1;
        rx_fetch   = EFP_FETCH_NONE;
    end
    // ========
    // Bus cycles; a released bus shows the inverse, never a stale value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clk);
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = reg_rdata;
            end
        end
    endtask : rd
    task automatic cmd_low(input int n);
        @(posedge clk);
        cmd_line_n <= 1'b0;
        repeat (n) @(posedge clk);
        cmd_line_n <= 1'b1;
    endtask : cmd_low
    task automatic fetch(input efp_fetch_t k);
        @(posedge clk);
        rx_fetch <= k;
        @(posedge clk);
        rx_fetch <= EFP_FETCH_NONE;
    endtask : fetch
endmodule : efp_host_model

// [verif/ext_event_flags_and_packet_options_tb.sv]
// Bench for the flag, mask and packet option register bank.
// Assumes the host model owns the register port and command line.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ext_event_flags_and_packet_options_tb
    import efp_pkg::*;
;
    logic clk, rst, reg_wr, reg_rd, reg_rvalid, cmd_line_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, legacy_event_mask;
    logic accept_plaintext_option, rx_bytes_pending, event_line;
    logic tx_launch, tx_flush, rx_drop, rx_hold_packets, rx_stream_paced;
    logic cts_carries_status, command_response_line_carries_status;
    logic [7:0] tx_buffered_len, tx_packet_len, len;
    efp_err_evt_t err_evt;
    efp_tx_evt_t  tx_evt;
    efp_rx_pkt_t  rx_pkt;
    efp_tx_trig_t tx_trig;
    efp_fetch_t   rx_fetch, rx_deliver, dk;
    int err_count, total_checks, lc, fc, dc;
    logic [7:0] amap [7] = '{ADDR_FLAG_HIGH, ADDR_FLAG_MID, ADDR_FLAG_LOW,
        ADDR_MASK_MID, ADDR_OPT_VOL, ADDR_OPT_NV, 8'h10};
    always #2 clk = ~clk;
    efp_host_model u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .cmd_line_n(cmd_line_n),
        .rx_fetch(rx_fetch));
    efp_regbank u_efp_regbank (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .legacy_event_mask(legacy_event_mask),
        .accept_plaintext_option(accept_plaintext_option),
        .err_evt(err_evt), .tx_evt(tx_evt), .rx_pkt(rx_pkt),
        .rx_bytes_pending(rx_bytes_pending), .tx_trig(tx_trig),
        .cmd_line_n(cmd_line_n), .tx_buffered_len(tx_buffered_len),
        .rx_fetch(rx_fetch), .event_line(event_line),
        .tx_launch(tx_launch), .tx_packet_len(tx_packet_len),
        .tx_flush(tx_flush), .rx_drop(rx_drop),
        .rx_hold_packets(rx_hold_packets),
        .rx_stream_paced(rx_stream_paced), .rx_deliver(rx_deliver),
        .cts_carries_status(cts_carries_status),
        .command_response_line_carries_status(command_response_line_carries_status));
    // ========
    // Tasks
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        u_host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            err_count++;
            complete_run();
        end else `CHK("read data", e, d)
    endtask : rchk
    task automatic pulse(efp_err_evt_t e, efp_tx_evt_t t, efp_rx_pkt_t p);
        @(posedge clk);
        err_evt <= e;
        tx_evt  <= t;
        rx_pkt  <= p;
        @(posedge clk);
        err_evt <= '0;
        tx_evt  <= '0;
        rx_pkt  <= '0;
    endtask : pulse
    // Counts output pulses; pulses are registered, so edges see them settled
    task automatic watch(input int n);
        lc = 0;
        fc = 0;
        dc = 0;
        dk = EFP_FETCH_NONE;
        repeat (n) begin
            @(posedge clk);
            lc += int'(tx_launch === 1'b1);
            fc += int'(tx_flush === 1'b1);
            dc += int'(rx_drop === 1'b1);
            if (tx_launch === 1'b1) len = tx_packet_len;
            if (rx_deliver !== EFP_FETCH_NONE) dk = rx_deliver;
        end
    endtask : watch
    task automatic trig(input efp_tx_trig_t t, input logic [7:0] n);
        fork
            begin
                @(posedge clk);
                tx_trig         <= t;
                tx_buffered_len <= n;
                @(posedge clk);
                tx_trig         <= '0;
                tx_buffered_len <= n + 8'h05; // Late bytes must not count
            end
            watch(6);
        join
    endtask : trig
    task automatic optw(input logic [7:0] v);
        fork
            u_host.wr(ADDR_OPT_VOL, v);
            watch(6);
        join
    endtask : optw
    // ========
    // Sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        legacy_event_mask = 8'h00;
        accept_plaintext_option = 1'b0;
        rx_bytes_pending = 1'b0;
        tx_buffered_len = 8'h00;
        err_evt = '0;
        tx_evt = '0;
        rx_pkt = '0;
        tx_trig = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        `CHK("event_line", 1'b0, event_line)
        for (int i = 0; i < 7; i++) rchk(amap[i], 8'h00);
        for (int i = 0; i < 8; i++) begin
            pulse(efp_err_evt_t'(8'h01 << i), '0, '0);
            rchk(ADDR_FLAG_LOW, 8'h01 << i);
            u_host.wr(ADDR_FLAG_LOW, 8'h00);
        end
        pulse(8'hFF, '0, '0);
        rchk(ADDR_FLAG_LOW, 8'hFF);
        rchk(ADDR_FLAG_LOW, 8'hFF);
        u_host.wr(ADDR_FLAG_LOW, 8'hF0);
        rchk(ADDR_FLAG_LOW, 8'hF0);
        u_host.wr(ADDR_FLAG_LOW, 8'hFF);
        rchk(ADDR_FLAG_LOW, 8'hF0);
        fork
            u_host.wr(ADDR_FLAG_LOW, 8'h00);
            pulse(8'h02, '0, '0);
        join
        rchk(ADDR_FLAG_LOW, 8'h02);
        u_host.wr(ADDR_MASK_LOW, 8'h02);
        @(negedge clk);
        `CHK("event_line", 1'b1, event_line)
        @(posedge clk);
        legacy_event_mask <= 8'h40;
        @(negedge clk);
        `CHK("event_line", 1'b0, event_line)
        @(posedge clk);
        legacy_event_mask <= 8'h00;
        u_host.wr(ADDR_FLAG_LOW, 8'h00);
        @(negedge clk);
        `CHK("event_line", 1'b0, event_line)
        pulse('0, 4'h8, '0);
        rchk(ADDR_FLAG_MID, 8'h01);
        u_host.wr(ADDR_FLAG_MID, 8'h00);
        pulse('0, 4'hC, '0);
        rchk(ADDR_FLAG_MID, 8'h00);
        pulse('0, 4'h2, '0);
        rchk(ADDR_FLAG_MID, 8'h01);
        u_host.wr(ADDR_FLAG_MID, 8'h00);
        pulse('0, 4'h1, '0);
        rchk(ADDR_FLAG_MID, 8'h20);
        u_host.wr(ADDR_FLAG_MID, 8'h00);
        @(posedge clk);
        accept_plaintext_option <= 1'b1;
        pulse('0, '0, 18'h20000);
        rchk(ADDR_FLAG_MID, 8'h04);
        u_host.wr(ADDR_FLAG_MID, 8'h00);
        @(posedge clk);
        accept_plaintext_option <= 1'b0;
        fork
            pulse('0, '0, 18'h20000);
            watch(5);
        join
        `CHK("rx_drop", 1, dc)
        rchk(ADDR_FLAG_MID, 8'h00);
        pulse('0, '0, 18'h30005);
        rchk(ADDR_FLAG_MID, 8'h00);
        pulse('0, '0, 18'h30003);
        rchk(ADDR_FLAG_MID, 8'h08);
        u_host.wr(ADDR_FLAG_MID, 8'h00);
        pulse('0, '0, 18'h30004);
        rchk(ADDR_FLAG_MID, 8'h00);
        pulse('0, '0, 18'h30007);
        rchk(ADDR_FLAG_MID, 8'h10);
        u_host.wr(ADDR_FLAG_MID, 8'h00);
        @(posedge clk);
        rx_bytes_pending <= 1'b1;
        u_host.wr(ADDR_FLAG_MID, 8'h00);
        rchk(ADDR_FLAG_MID, 8'h02);
        @(posedge clk);
        rx_bytes_pending <= 1'b0;
        rchk(ADDR_FLAG_MID, 8'h00);
        u_host.wr(ADDR_FLAG_HIGH, 8'hFF);
        rchk(ADDR_FLAG_HIGH, 8'h00);
        u_host.wr(ADDR_OPT_NV, 8'hA5);
        rchk(ADDR_OPT_NV, 8'h05);
        optw(8'hF3);
        `CHK("tx_flush", 1, fc)
        rchk(ADDR_OPT_VOL, 8'h03);
        trig(4'h8, 8'h09);
        `CHK("tx_launch", 0, lc)
        trig(4'h4, 8'h09);
        `CHK("tx_launch", 0, lc)
        trig(4'h1, 8'h07);
        `CHK("tx_launch", 1, lc)
        `CHK("tx_packet_len", 8'h07, len)
        fork
            u_host.cmd_low(3);
            watch(8);
        join
        `CHK("tx_launch", 1, lc)
        optw(8'h00);
        `CHK("tx_flush", 1, fc)
        for (int i = 0; i < 4; i++) begin
            trig(efp_tx_trig_t'(4'h1 << i), 8'h10 + 8'(i));
            `CHK("tx_launch", 1, lc)
            `CHK("tx_packet_len", 8'h10 + 8'(i), len)
        end
        fork
            u_host.cmd_low(3);
            watch(8);
        join
        `CHK("tx_launch", 0, lc)
        optw(8'h04);
        `CHK("rx_hold_packets", 1'b1, rx_hold_packets)
        `CHK("rx_stream_paced", 1'b0, rx_stream_paced)
        for (int k = 1; k < 4; k++) begin
            fork
                u_host.fetch(efp_fetch_t'(k));
                watch(4);
            join
            `CHK("rx_deliver", efp_fetch_t'(k), dk)
        end
        optw(8'h08);
        `CHK("rx_stream_paced", 1'b1, rx_stream_paced)
        `CHK("cts_carries_status", 1'b1, cts_carries_status)
        `CHK("command_response_line_carries_status", 1'b0, command_response_line_carries_status)
        fork
            u_host.fetch(EFP_FETCH_BOTH);
            watch(4);
        join
        `CHK("rx_deliver", EFP_FETCH_NONE, dk)
        optw(8'h00);
        `CHK("cts_carries_status", 1'b0, cts_carries_status)
        `CHK("command_response_line_carries_status", 1'b1, command_response_line_carries_status)
        complete_run();
    end
endmodule : ext_event_flags_and_packet_options_tb
